/* inc/nsi_pkg.sv */
// Purpose: constants and types for the numeric sensor setup handler
// Assumes: one synchronous clock domain, classic wishbone register access
// Notes:   encodings not fixed by the protocol are plain defaults here
package nsi_pkg;
  // -------------------------------------------------------------------
  // table size and widths
  // -------------------------------------------------------------------
  localparam int          NUM_SENSORS  = 4;
  localparam int          SIDX_W       = 2;
  localparam logic [15:0] HANDLE_ZERO  = 16'h0000; // reserved handle
  localparam logic [15:0] HANDLE_ONES  = 16'hffff; // reserved handle
  // -------------------------------------------------------------------
  // result codes
  // -------------------------------------------------------------------
  localparam logic [7:0] RC_SUCCESS      = 8'h00;
  localparam logic [7:0] RC_INVALID_DATA = 8'h02;
  localparam logic [7:0] BAD_HANDLE_CODE = 8'h80;
  // -------------------------------------------------------------------
  // field encodings
  // -------------------------------------------------------------------
  localparam logic [7:0] OP_ENABLED     = 8'h00;
  localparam logic [7:0] OP_DISABLED    = 8'h01;
  localparam logic [7:0] OP_UNAVAILABLE = 8'h02;
  localparam logic [7:0] EVENTS_ON      = 8'h01;
  localparam logic [7:0] EVENTS_OFF     = 8'h00;
  localparam logic [7:0] KEEP_SETTING   = 8'hff;
  localparam logic [7:0] FLAG_FALSE     = 8'h00;
  // value_width_sel codes
  localparam logic [2:0] VW_U8  = 3'h0;
  localparam logic [2:0] VW_S8  = 3'h1;
  localparam logic [2:0] VW_U16 = 3'h2;
  localparam logic [2:0] VW_S16 = 3'h3;
  localparam logic [2:0] VW_U32 = 3'h4;
  localparam logic [2:0] VW_S32 = 3'h5;
  // -------------------------------------------------------------------
  // register map (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [7:0] ADR_IRQ_STATUS  = 8'h00;
  localparam logic [7:0] ADR_IRQ_MASK    = 8'h04;
  localparam logic [7:0] ADR_LAST_RESULT = 8'h08;
  localparam logic [7:0] ADR_SENSOR_BASE = 8'h20;
  localparam int         SENSOR_STRIDE_LSB = 4; // 16 bytes per sensor
  localparam logic [1:0] SREG_HANDLE = 2'h0;
  localparam logic [1:0] SREG_CFG    = 2'h1;
  localparam logic [1:0] SREG_STATE  = 2'h2;
  localparam logic [1:0] SREG_VALUE  = 2'h3;
  // irq bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_W    = 2;
  // reset values
  localparam logic [7:0] RST_OP_STATE = OP_DISABLED;
  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE, ST_CHECK, ST_FIELDS, ST_OPSTATE
  } nsi_state_type;

  typedef struct packed {
    logic [15:0] handle;
    logic [2:0]  width_sel;
    logic        ignore_preload;
    logic [7:0]  op_state;
    logic [7:0]  present_state;
    logic        events_en;
    logic [31:0] current_value;
  } nsi_sensor_type;
endpackage : nsi_pkg

/* verilog/nsi_numeric_sensor_init.sv */
// Purpose: responder for the numeric sensor setup command
// Assumes: requester holds fields stable while cmd_valid_in is high
// Notes:   sensor table is configured and observed over wishbone
//
// How it works
// R01 - handles 0000/ffff are never assigned or matched
// R02 - one-byte result, 80h for unknown handle
// R03 - operational state applied after all other fields
// R04 - operational state limited to three choices
// R05 - event control on, off, ffh keeps setting
// R06 - preload value loaded only when flag true
// R07 - preload sized to data width, becomes current value
// R08 - sensor may ignore preload even when flagged
// R09 - present state stored exactly as supplied
// R10 - requester supplies fields in documented order
// R11 - avoid virtual sensors needing agent setup
// R12 - data width is one of six formats
// R13 - unknown handle rejected before touching anything
`timescale 1ns/100ps
module nsi_numeric_sensor_init (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // command request
  input  wire logic        cmd_valid_in,
  input  wire logic [15:0] sensor_handle_in,
  input  wire logic [7:0]  op_state_target_in,
  input  wire logic [7:0]  present_state_target_in,
  input  wire logic [7:0]  event_msg_ctrl_in,
  input  wire logic [7:0]  load_reading_flag_in,
  input  wire logic [31:0] initial_reading_value_in,
  output logic             cmd_ready_out,
  // command response
  output logic             resp_valid_out,
  output logic [7:0]       result_code_out,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // interrupt
  output logic             irq_out
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    nsi_pkg::nsi_state_type                         state;
    logic                                           ready;
    logic                                           resp_valid;
    logic [7:0]                                     result;
    logic [15:0]                                    r_handle;
    logic [7:0]                                     r_op;
    logic [7:0]                                     r_present;
    logic [7:0]                                     r_event;
    logic [7:0]                                     r_flag;
    logic [31:0]                                    r_value;
    logic [nsi_pkg::SIDX_W-1:0]                     hit_idx;
    logic [nsi_pkg::NUM_SENSORS-1:0][$bits(nsi_pkg::nsi_sensor_type)-1:0]
                                                    sensors;
    logic [nsi_pkg::IRQ_W-1:0]                      irq_status;
    logic [nsi_pkg::IRQ_W-1:0]                      irq_mask;
    logic                                           irq;
    logic                                           ack;
    logic [31:0]                                    rdata;
  } nsi_regs_type;

  nsi_regs_type state_ff;
  nsi_regs_type nxt_state;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // fit a preload to the sensor width: truncate then zero or sign extend
  function automatic logic [31:0] nsi_fit(input logic [2:0]  sel,
                                          input logic [31:0] v);
    logic [31:0] r;
    r = v;
    case (sel)
      nsi_pkg::VW_U8:  r = {24'h000000, v[7:0]};
      nsi_pkg::VW_S8:  r = {{24{v[7]}}, v[7:0]};
      nsi_pkg::VW_U16: r = {16'h0000, v[15:0]};
      nsi_pkg::VW_S16: r = {{16{v[15]}}, v[15:0]};
      default:         r = v;
    endcase
    return r;
  endfunction : nsi_fit

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] nsi_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : nsi_merge

  // -------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------
  // handle compare, command sequencing, register file, interrupt
  always_comb begin
    nsi_pkg::nsi_sensor_type s;
    logic                    hit;
    logic [nsi_pkg::SIDX_W-1:0] idx;
    logic                    fields_ok;
    logic                    wr;
    logic                    rd;
    logic [nsi_pkg::IRQ_W-1:0] ev;
    logic [1:0]              sreg;
    logic [nsi_pkg::SIDX_W-1:0] sidx;
    logic                    in_tbl;
    logic [31:0]             w;
    logic [7:0]              toff;
    s         = '0;
    hit       = 1'b0;
    idx       = '0;
    fields_ok = 1'b0;
    ev        = '0;
    w         = '0;
    wr        = 1'b0;
    rd        = 1'b0;
    sreg      = '0;
    sidx      = '0;
    in_tbl    = 1'b0;
    toff      = '0;
    nxt_state = state_ff;
    nxt_state.resp_valid = 1'b0;

    // handle lookup; reserved handles never match a sensor
    for (int i = 0; i < nsi_pkg::NUM_SENSORS; i++) begin
      s = state_ff.sensors[i];
      if (s.handle == state_ff.r_handle &&
          s.handle != nsi_pkg::HANDLE_ZERO &&
          s.handle != nsi_pkg::HANDLE_ONES) begin // R01
        hit = 1'b1;
        idx = nsi_pkg::SIDX_W'(i);
      end
    end
    // field validity checked up front so a reject changes nothing
    fields_ok = (state_ff.r_op == nsi_pkg::OP_ENABLED ||
                 state_ff.r_op == nsi_pkg::OP_DISABLED ||
                 state_ff.r_op == nsi_pkg::OP_UNAVAILABLE) && // R04
                (state_ff.r_event == nsi_pkg::EVENTS_ON ||
                 state_ff.r_event == nsi_pkg::EVENTS_OFF ||
                 state_ff.r_event == nsi_pkg::KEEP_SETTING);

    // command sequencer
    case (state_ff.state)
      nsi_pkg::ST_IDLE: begin
        if (cmd_valid_in && state_ff.ready) begin
          nxt_state.ready     = 1'b0;
          nxt_state.r_handle  = sensor_handle_in;
          nxt_state.r_op      = op_state_target_in;
          nxt_state.r_present = present_state_target_in;
          nxt_state.r_event   = event_msg_ctrl_in;
          nxt_state.r_flag    = load_reading_flag_in;
          nxt_state.r_value   = initial_reading_value_in;
          nxt_state.state     = nsi_pkg::ST_CHECK;
        end
      end
      nsi_pkg::ST_CHECK: begin
        nxt_state.hit_idx = idx;
        if (!hit) begin
          nxt_state.result     = nsi_pkg::BAD_HANDLE_CODE; // R02 R13
          nxt_state.resp_valid = 1'b1;
          nxt_state.ready      = 1'b1;
          nxt_state.state      = nsi_pkg::ST_IDLE;
          ev[nsi_pkg::IRQ_ERR] = 1'b1;
        end else if (!fields_ok) begin
          nxt_state.result     = nsi_pkg::RC_INVALID_DATA; // R02
          nxt_state.resp_valid = 1'b1;
          nxt_state.ready      = 1'b1;
          nxt_state.state      = nsi_pkg::ST_IDLE;
          ev[nsi_pkg::IRQ_ERR] = 1'b1;
        end else begin
          nxt_state.state = nsi_pkg::ST_FIELDS;
        end
      end
      nsi_pkg::ST_FIELDS: begin
        // present state, event control and preload go first
        s = state_ff.sensors[state_ff.hit_idx];
        s.present_state = state_ff.r_present; // R09
        if (state_ff.r_event == nsi_pkg::EVENTS_ON) begin
          s.events_en = 1'b1; // R05
        end else if (state_ff.r_event == nsi_pkg::EVENTS_OFF) begin
          s.events_en = 1'b0; // R05
        end
        if (state_ff.r_flag != nsi_pkg::FLAG_FALSE &&
            !s.ignore_preload) begin // R06 R08
          s.current_value = nsi_fit(s.width_sel, state_ff.r_value); // R07 R12
        end
        nxt_state.sensors[state_ff.hit_idx] = s;
        nxt_state.state = nsi_pkg::ST_OPSTATE;
      end
      nsi_pkg::ST_OPSTATE: begin
        // operational state lands one cycle after the other fields
        s = state_ff.sensors[state_ff.hit_idx];
        s.op_state = state_ff.r_op; // R03
        nxt_state.sensors[state_ff.hit_idx] = s;
        nxt_state.result     = nsi_pkg::RC_SUCCESS; // R02
        nxt_state.resp_valid = 1'b1;
        nxt_state.ready      = 1'b1;
        nxt_state.state      = nsi_pkg::ST_IDLE;
        ev[nsi_pkg::IRQ_DONE] = 1'b1;
      end
      default: begin
        nxt_state.state = nsi_pkg::ST_IDLE;
        nxt_state.ready = 1'b1;
      end
    endcase

    // wishbone: ack one cycle after the strobe, dropped the next
    wr   = wb_cyc_in && wb_stb_in && !state_ff.ack && wb_we_in;
    rd   = wb_cyc_in && wb_stb_in && !state_ff.ack && !wb_we_in;
    nxt_state.ack = wb_cyc_in && wb_stb_in && !state_ff.ack;
    sreg = wb_adr_in[3:2];
    // slots sit above the base, so decode from the offset, not the address
    toff = wb_adr_in - nsi_pkg::ADR_SENSOR_BASE;
    sidx = toff[nsi_pkg::SENSOR_STRIDE_LSB +: nsi_pkg::SIDX_W];
    in_tbl = wb_adr_in >= nsi_pkg::ADR_SENSOR_BASE &&
             toff[7:nsi_pkg::SENSOR_STRIDE_LSB + nsi_pkg::SIDX_W] == '0;

    // register writes; sensor slots stay untouched while a command runs
    if (wr) begin
      if (wb_adr_in == nsi_pkg::ADR_IRQ_MASK && wb_sel_in[0]) begin
        nxt_state.irq_mask = wb_dat_in[nsi_pkg::IRQ_W-1:0];
      end
      if (in_tbl && state_ff.state == nsi_pkg::ST_IDLE) begin
        s = state_ff.sensors[sidx];
        if (sreg == nsi_pkg::SREG_HANDLE) begin
          w = nsi_merge({16'h0000, s.handle}, wb_dat_in, wb_sel_in);
          // reserved handle values are never assigned
          if (w[15:0] != nsi_pkg::HANDLE_ZERO &&
              w[15:0] != nsi_pkg::HANDLE_ONES) begin // R01
            s.handle = w[15:0];
          end
        end else if (sreg == nsi_pkg::SREG_CFG && wb_sel_in[0]) begin
          if (wb_dat_in[2:0] <= nsi_pkg::VW_S32) begin // R12
            s.width_sel = wb_dat_in[2:0];
          end
          s.ignore_preload = wb_dat_in[3]; // R08
        end
        nxt_state.sensors[sidx] = s;
      end
    end

    // sticky status: write one clears, a new event wins over the clear
    if (wr && wb_adr_in == nsi_pkg::ADR_IRQ_STATUS && wb_sel_in[0]) begin
      nxt_state.irq_status = state_ff.irq_status &
                             ~wb_dat_in[nsi_pkg::IRQ_W-1:0];
    end
    nxt_state.irq_status = nxt_state.irq_status | ev;
    nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);

    // read data; unmapped addresses read as zero
    nxt_state.rdata = '0;
    if (rd) begin
      if (wb_adr_in == nsi_pkg::ADR_IRQ_STATUS) begin
        nxt_state.rdata[nsi_pkg::IRQ_W-1:0] = state_ff.irq_status;
      end else if (wb_adr_in == nsi_pkg::ADR_IRQ_MASK) begin
        nxt_state.rdata[nsi_pkg::IRQ_W-1:0] = state_ff.irq_mask;
      end else if (wb_adr_in == nsi_pkg::ADR_LAST_RESULT) begin
        nxt_state.rdata = {state_ff.r_handle, 8'h00, state_ff.result};
      end else if (in_tbl) begin
        s = state_ff.sensors[sidx];
        case (sreg)
          nsi_pkg::SREG_HANDLE: nxt_state.rdata = {16'h0000, s.handle};
          nsi_pkg::SREG_CFG:
            nxt_state.rdata = {28'h0000000, s.ignore_preload, s.width_sel};
          nsi_pkg::SREG_STATE:
            nxt_state.rdata = {15'h0000, s.events_en, s.present_state,
                               s.op_state};
          default:              nxt_state.rdata = s.current_value;
        endcase
      end
    end
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  // reset: handles zero so no sensor answers until software names one
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff       <= '0;
      state_ff.state <= nsi_pkg::ST_IDLE;
      state_ff.ready <= 1'b1;
      for (int i = 0; i < nsi_pkg::NUM_SENSORS; i++) begin
        state_ff.sensors[i] <= {16'h0000, nsi_pkg::VW_U8, 1'b0,
                                nsi_pkg::RST_OP_STATE, 8'h00, 1'b0,
                                32'h00000000};
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // -------------------------------------------------------------------
  // outputs, all straight from flops
  // -------------------------------------------------------------------
  assign cmd_ready_out   = state_ff.ready;
  assign resp_valid_out  = state_ff.resp_valid;
  assign result_code_out = state_ff.result;
  assign wb_dat_out      = state_ff.rdata;
  assign wb_ack_out      = state_ff.ack;
  assign irq_out         = state_ff.irq;
endmodule : nsi_numeric_sensor_init

/* test/nsi_requester.sv */
// Purpose: requester model issuing numeric sensor setup commands
// Assumes: one request in flight, fields held until the handler takes it
// Notes:   released fields show an inverted pattern, never the old value
`timescale 1ns/100ps
module nsi_requester (
  // clock and handshake
  input  wire logic        clk_in,
  input  wire logic        ready_in,
  // request fields
  output logic             valid_out,
  output logic [15:0]      handle_out,
  output logic [7:0]       op_out,
  output logic [7:0]       present_out,
  output logic [7:0]       event_out,
  output logic [7:0]       flag_out,
  output logic [31:0]      value_out
);
  // idle at time zero
  initial begin
    valid_out = 1'b0;
    {handle_out, op_out, present_out, event_out, flag_out, value_out} = '0;
  end
  // one whole request; single path to the table while it runs
  task automatic send(input logic [15:0] h, input logic [7:0] op, ps, ev,
                      input logic [7:0] fl, input logic [31:0] v);
    @(posedge clk_in);
    valid_out <= 1'b1;
    {handle_out, op_out, present_out} <= {h, op, ps};
    {event_out, flag_out, value_out} <= {ev, fl, v};
    do @(posedge clk_in); while (ready_in !== 1'b1);
    valid_out <= 1'b0;
    {handle_out, op_out, present_out} <= ~{h, op, ps};
    {event_out, flag_out, value_out} <= ~{ev, fl, v};
  endtask : send
endmodule : nsi_requester

/* test/nsi_numeric_sensor_init_properties.sv */
// Purpose: port timing checks of the numeric sensor setup handler
// Assumes: single clock, synchronous active-high reset
// Notes:   bad handle beats bad field only for handles 0000/ffff, else precedence is left open
`timescale 1ns/100ps
module nsi_numeric_sensor_init_properties (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // command side
  input wire logic        cmd_valid_in,
  input wire logic [15:0] sensor_handle_in,
  input wire logic [7:0]  op_state_target_in,
  input wire logic [7:0]  event_msg_ctrl_in,
  input wire logic        cmd_ready_out,
  input wire logic        resp_valid_out,
  input wire logic [7:0]  result_code_out,
  // wishbone side
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out
);
  logic take_w;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // helper so $past sees a plain signal
  assign take_w = cmd_valid_in && cmd_ready_out;
  sequence s_take;
    take_w;
  endsequence
  // refusal answer two cycles after the take
  sequence s_refuse;
    ##2 resp_valid_out && result_code_out != 8'h00;
  endsequence
  a_take_busy: assert property (
    s_take |=> !cmd_ready_out) else $error("ready high after take");
  a_resp_time: assert property (
    s_take |-> ##[2:4] resp_valid_out) else $error("no answer in time");
  a_bad_handle: assert property (
    s_take ##0 (sensor_handle_in inside {16'h0000, 16'hffff}) |->
      s_refuse ##0 result_code_out == 8'h80) else $error("handle not refused");
  a_bad_op: assert property (
    s_take ##0 op_state_target_in > 8'h02 |-> s_refuse)
    else $error("illegal op state accepted");
  a_bad_event: assert property (
    s_take ##0 !(event_msg_ctrl_in inside {8'h00, 8'h01, 8'hff}) |-> s_refuse)
    else $error("illegal event code accepted");
  a_ok_late: assert property (
    resp_valid_out && result_code_out == 8'h00 |-> $past(take_w, 4))
    else $error("success not four cycles after take");
  a_err_early: assert property (
    resp_valid_out && result_code_out != 8'h00 |-> $past(take_w, 2))
    else $error("refusal not two cycles after take");
  a_resp_ready: assert property (
    resp_valid_out |-> cmd_ready_out ##1 !resp_valid_out)
    else $error("answer pulse or ready wrong");
  a_result_hold: assert property (
    !resp_valid_out |-> $stable(result_code_out)) else $error("result moved");
  a_ack_next: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not one cycle after strobe");
  a_dat_idle: assert property (
    !wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
endmodule : nsi_numeric_sensor_init_properties
bind nsi_numeric_sensor_init nsi_numeric_sensor_init_properties nsi_props_i (
  .clk_in, .reset_in, .cmd_valid_in, .sensor_handle_in, .op_state_target_in,
  .event_msg_ctrl_in, .cmd_ready_out, .resp_valid_out, .result_code_out,
  .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out);

/* test/testbench.sv */
// Purpose: self-checking bench for the numeric sensor setup handler
// Assumes: requester model drives the command side
// Notes:   bad data is only sent to known handles, precedence is open
`timescale 1ns/100ps
module testbench;
  logic        clk_in, reset_in, cmd_valid_in, cmd_ready_out, resp_valid_out;
  logic [15:0] sensor_handle_in;
  logic [7:0]  op_state_target_in, present_state_target_in, event_msg_ctrl_in;
  logic [7:0]  load_reading_flag_in, result_code_out, wb_adr_in, rc;
  logic [31:0] initial_reading_value_in, wb_dat_in, wb_dat_out, q, r, v;
  logic        wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, irq_out;
  logic [3:0]  wb_sel_in;
  logic [15:0] hnd [4];
  logic [2:0]  wsel [4];
  logic [31:0] e_st [4], e_val [4];
  logic [7:0]  evs [3] = '{8'h00, 8'h01, 8'hff};
  logic [15:0] badh [3] = '{16'h0000, 16'hffff, 16'h8000};
  int          miscompares, n_checks, seed, k;
  nsi_numeric_sensor_init nsi_numeric_sensor_init_i (.clk_in, .reset_in,
    .cmd_valid_in, .sensor_handle_in, .op_state_target_in,
    .present_state_target_in, .event_msg_ctrl_in, .load_reading_flag_in,
    .initial_reading_value_in, .cmd_ready_out, .resp_valid_out,
    .result_code_out, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .irq_out);
  nsi_requester nsi_requester_i (.clk_in, .ready_in(cmd_ready_out),
    .valid_out(cmd_valid_in), .handle_out(sensor_handle_in),
    .op_out(op_state_target_in), .present_out(present_state_target_in),
    .event_out(event_msg_ctrl_in), .flag_out(load_reading_flag_in),
    .value_out(initial_reading_value_in));
  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // preload truncated to the width and then extended
  function automatic logic [31:0] extw(input logic [2:0] s, logic [31:0] v);
    case (s)
      nsi_pkg::VW_U8:  return {24'h0, v[7:0]};
      nsi_pkg::VW_S8:  return {{24{v[7]}}, v[7:0]};
      nsi_pkg::VW_U16: return {16'h0, v[15:0]};
      nsi_pkg::VW_S16: return {{16{v[15]}}, v[15:0]};
      default:         return v;
    endcase
  endfunction : extw
  function automatic logic [7:0] sa(input int i, logic [1:0] reg_sel);
    return nsi_pkg::ADR_SENSOR_BASE + 8'(i * 16) + {4'h0, reg_sel, 2'b00};
  endfunction : sa
  task automatic chk32(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: reg got %h want %h", $time, g, e);
    end
  endtask : chk32
  task automatic chk8(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: code got %h want %h", $time, g, e);
    end
  endtask : chk8
  // classic cycle, held until ack is sampled, then released a cycle
  task automatic wb(input logic we, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, a, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("wrong value at %0t: no bus ack", $time);
    end
    q = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
    @(posedge clk_in);
  endtask : wb
  task automatic rdc(input logic [7:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk32(q, e);
  endtask : rdc
  // send one command and wait for its answer pulse
  task automatic cmd(input logic [15:0] h, logic [7:0] op, ps, ev, fl,
                     input logic [31:0] v);
    int n;
    n = 0;
    nsi_requester_i.send(h, op, ps, ev, fl, v);
    do begin @(posedge clk_in); n++; end while (resp_valid_out !== 1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("wrong value at %0t: no command answer", $time);
    end
    rc = result_code_out;
  endtask : cmd
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  // main sequence
  initial begin
    seed = 2;
    {miscompares, n_checks} = '0;
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
    wb_sel_in = 4'hf;
    reset_in = 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(nsi_pkg::ADR_IRQ_STATUS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdc(sa(i, nsi_pkg::SREG_STATE), 32'h1);
      r = $random(seed);
      hnd[i] = {4'(i + 1), r[11:0]};
      wsel[i] = (i == 3) ? nsi_pkg::VW_S32 : 3'(r[31:16] % 6);
      {e_st[i], e_val[i]} = {32'h1, 32'h0};
      wb(1'b1, sa(i, nsi_pkg::SREG_HANDLE), {16'h0, hnd[i]});
      wb(1'b1, sa(i, nsi_pkg::SREG_CFG), {28'h0, i == 3, wsel[i]});
    end
    wb(1'b1, nsi_pkg::ADR_IRQ_MASK, 32'h3);
    rdc(8'hfc, 32'h0);
    $display("test done: reset and setup");
    repeat (16) begin
      r = $random(seed);
      k = r[1:0];
      v = $random(seed);
      cmd(hnd[k], 8'(r[3:2] % 3), r[15:8], evs[r[5:4] % 3],
          r[6] ? (r[23:16] | 8'h01) : 8'h00, v);
      chk8(rc, nsi_pkg::RC_SUCCESS);
      if (r[5:4] % 3 != 2) e_st[k][16] = (r[5:4] % 3 == 1);
      e_st[k][15:0] = {r[15:8], 8'(r[3:2] % 3)};
      if (r[6] && k != 3) e_val[k] = extw(wsel[k], v);
      rdc(sa(k, nsi_pkg::SREG_STATE), e_st[k]);
      rdc(sa(k, nsi_pkg::SREG_VALUE), e_val[k]);
    end
    $display("test done: random commands");
    foreach (badh[j]) begin
      cmd(badh[j], 8'h00, 8'h5a, 8'h01, 8'h01, r);
      chk8(rc, nsi_pkg::BAD_HANDLE_CODE);
    end
    cmd(hnd[0], 8'h03, 8'h33, 8'h01, 8'h01, r);
    chk8(rc, nsi_pkg::RC_INVALID_DATA);
    cmd(hnd[0], 8'h00, 8'h33, 8'h02, 8'h01, r);
    chk8(rc, nsi_pkg::RC_INVALID_DATA);
    rdc(nsi_pkg::ADR_LAST_RESULT,
        {hnd[0], 8'h00, nsi_pkg::RC_INVALID_DATA});
    rdc(sa(0, nsi_pkg::SREG_STATE), e_st[0]);
    rdc(sa(0, nsi_pkg::SREG_VALUE), e_val[0]);
    rdc(nsi_pkg::ADR_IRQ_STATUS, 32'h3);
    chk8({7'h0, irq_out}, 8'h01);
    wb(1'b1, nsi_pkg::ADR_IRQ_STATUS, 32'h3);
    chk8({7'h0, irq_out}, 8'h00);
    wb(1'b1, nsi_pkg::ADR_IRQ_MASK, 32'h2);
    cmd(hnd[1], 8'h01, 8'h00, 8'hff, 8'h00, r);
    chk8({7'h0, irq_out}, 8'h00);
    wb(1'b1, nsi_pkg::ADR_IRQ_MASK, 32'h1);
    chk8({7'h0, irq_out}, 8'h01);
    $display("test done: refusals and interrupt");
    wrap_up();
  end
endmodule : testbench
